// ### core/pio_consts.svh
// address indices, field masks and reset values of the parallel port block
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

`define PIO_IDX_PORT_A_DATA 4'h0
`define PIO_IDX_PORT_B_DATA 4'h1
`define PIO_IDX_PORT_C_DATA 4'h2
`define PIO_IDX_PORT_D_DATA 4'h3
`define PIO_IDX_PORT_A_DIR  4'h4
`define PIO_IDX_PORT_B_DIR  4'h5
`define PIO_IDX_PORT_C_DIR  4'h6
`define PIO_IDX_PORT_D_DIR  4'h7
`define PIO_IDX_PORT_E_DATA 4'h8
`define PIO_IDX_PORT_F_DATA 4'h9
`define PIO_IDX_PORT_G_DATA 4'ha
`define PIO_IDX_PORT_H_DATA 4'hb
`define PIO_IDX_PORT_E_DIR  4'hc
`define PIO_IDX_PORT_F_DIR  4'hd
`define PIO_IDX_PORT_G_DIR  4'he
`define PIO_IDX_PORT_H_DIR  4'hf

`define PIO_PORT_A 3'h0
`define PIO_PORT_B 3'h1
`define PIO_PORT_C 3'h2
`define PIO_PORT_D 3'h3
`define PIO_PORT_E 3'h4
`define PIO_PORT_F 3'h5
`define PIO_PORT_G 3'h6
`define PIO_PORT_H 3'h7

`define PIO_MASK_DATA 64'h0307_7fff_ff3f_ffff
`define PIO_MASK_DIR  64'h0307_7fff_ffbf_ffff
`define PIO_DIR_RESET 64'h0000_0000_0000_0000

`define PIO_CLKOUT_BIT 7
`define PIO_CLKOUT_PIN 2
`define PIO_ADC_CHANS  5'h08
`define PIO_ADDR_HI    7:6
`define PIO_ADDR_IDX   5:2
`define PIO_RESP_OKAY   2'h0
`define PIO_RESP_DECERR 2'h3

`endif

// ### core/pio_pkg.sv
// types shared by the parallel port block
package pio_pkg;
  typedef logic [7:0][7:0] pio_pins_t;
  typedef enum logic [1:0] {
    PIO_WR_IDLE  = 2'b00,
    PIO_WR_ADDR  = 2'b01,
    PIO_WR_DATA  = 2'b10,
    PIO_WR_RESP  = 2'b11
  } pio_wr_state_t;
endpackage

// ### core/pio_sync_if.sv
// carrier between the port core and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface pio_sync_if;
  pio_pkg::pio_pins_t raw;
  pio_pkg::pio_pins_t synced;
  modport core (output raw, input synced);
  modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ### core/pio_sync.sv
// two-stage synchroniser for every pin input
`timescale 1ns/1ps
`default_nettype none
module pio_sync (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic ce,
  pio_sync_if.sync  sif
);
  import pio_pkg::*;

  pio_pins_t meta_ff;
  pio_pins_t sync_ff;

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1)
    begin : g_bit
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_ff[g / 8][g % 8] <= 1'b0;
          sync_ff[g / 8][g % 8] <= 1'b0;
        end
        else if (ce)
        begin
          meta_ff[g / 8][g % 8] <= sif.raw[g / 8][g % 8];
          sync_ff[g / 8][g % 8] <= meta_ff[g / 8][g % 8];
        end
      end
    end
  endgenerate

  assign sif.synced = sync_ff;
endmodule
`default_nettype wire

// ### core/pio_top.sv
// parallel i/o ports a to h with an axi4-lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pio_consts.svh"

module pio_top (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic [7:0]        s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [7:0]        s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  output logic [31:0]            s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  input  wire pio_pkg::pio_pins_t pin_in,
  output pio_pkg::pio_pins_t     pin_out,
  output pio_pkg::pio_pins_t     pin_oe,
  input  wire logic [4:0]        converter_channel_select,
  output logic [7:0]             converter_channel_inputs,
  output logic [7:0]             converter_pin_claim
);
  import pio_pkg::*;

  pio_wr_state_t wr_state_ff;
  pio_wr_state_t nxt_wr_state;
  logic [7:0]    awaddr_ff;
  logic [31:0]   wdata_ff;
  logic [3:0]    wstrb_ff;
  logic [1:0]    bresp_ff;
  logic [31:0]   rdata_ff;
  logic [1:0]    rresp_ff;
  logic          rvalid_ff;
  pio_pins_t     latch_ff;
  pio_pins_t     dir_ff;
  pio_pins_t     pin_view;
  pio_pins_t     mask_data;
  pio_pins_t     mask_dir;
  logic          wr_fire;
  logic [7:0]    wr_addr;
  logic [7:0]    wr_byte;
  logic          wr_lane0;
  logic          wr_is_dir;
  logic [2:0]    wr_port;
  logic          rd_is_dir;
  logic [2:0]    rd_port;
  logic [7:0]    rd_byte;
  logic          ar_fire;
  logic          clk_out_en;

  pio_sync_if sif ();

  pio_sync u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .sif     (sif)
  );

  assign sif.raw   = pin_in;
  assign mask_data = `PIO_MASK_DATA;
  assign mask_dir  = `PIO_MASK_DIR;
  assign clk_out_en = dir_ff[`PIO_PORT_C][`PIO_CLKOUT_BIT];

  // pins handed to the converter by the channel select
  always_comb
  begin
    converter_pin_claim = 8'h00;
    if (converter_channel_select < `PIO_ADC_CHANS)
    begin
      converter_pin_claim[converter_channel_select[2:0]] = 1'b1;
    end
  end

  assign converter_channel_inputs = pin_in[`PIO_PORT_B];

  // index decode shared by read and write
  function automatic logic [3:0] pio_decode(input logic [3:0] idx);
    logic [3:0] r;
    r = 4'h0;
    unique case (idx)
      `PIO_IDX_PORT_A_DATA: r = {1'b0, `PIO_PORT_A};
      `PIO_IDX_PORT_B_DATA: r = {1'b0, `PIO_PORT_B};
      `PIO_IDX_PORT_C_DATA: r = {1'b0, `PIO_PORT_C};
      `PIO_IDX_PORT_D_DATA: r = {1'b0, `PIO_PORT_D};
      `PIO_IDX_PORT_A_DIR:  r = {1'b1, `PIO_PORT_A};
      `PIO_IDX_PORT_B_DIR:  r = {1'b1, `PIO_PORT_B};
      `PIO_IDX_PORT_C_DIR:  r = {1'b1, `PIO_PORT_C};
      `PIO_IDX_PORT_D_DIR:  r = {1'b1, `PIO_PORT_D};
      `PIO_IDX_PORT_E_DATA: r = {1'b0, `PIO_PORT_E};
      `PIO_IDX_PORT_F_DATA: r = {1'b0, `PIO_PORT_F};
      `PIO_IDX_PORT_G_DATA: r = {1'b0, `PIO_PORT_G};
      `PIO_IDX_PORT_H_DATA: r = {1'b0, `PIO_PORT_H};
      `PIO_IDX_PORT_E_DIR:  r = {1'b1, `PIO_PORT_E};
      `PIO_IDX_PORT_F_DIR:  r = {1'b1, `PIO_PORT_F};
      `PIO_IDX_PORT_G_DIR:  r = {1'b1, `PIO_PORT_G};
      `PIO_IDX_PORT_H_DIR:  r = {1'b1, `PIO_PORT_H};
    endcase
    return r;
  endfunction

  // write channel handshake
  always_comb
  begin
    nxt_wr_state   = wr_state_ff;
    s_axil_awready = 1'b0;
    s_axil_wready  = 1'b0;
    wr_fire        = 1'b0;
    unique case (wr_state_ff)
      PIO_WR_IDLE:
      begin
        s_axil_awready = ce;
        s_axil_wready  = ce;
        if (ce && s_axil_awvalid && s_axil_wvalid)
        begin
          wr_fire      = 1'b1;
          nxt_wr_state = PIO_WR_RESP;
        end
        else if (ce && s_axil_awvalid)
        begin
          nxt_wr_state = PIO_WR_ADDR;
        end
        else if (ce && s_axil_wvalid)
        begin
          nxt_wr_state = PIO_WR_DATA;
        end
      end
      PIO_WR_ADDR:
      begin
        s_axil_wready = ce;
        if (ce && s_axil_wvalid)
        begin
          wr_fire      = 1'b1;
          nxt_wr_state = PIO_WR_RESP;
        end
      end
      PIO_WR_DATA:
      begin
        s_axil_awready = ce;
        if (ce && s_axil_awvalid)
        begin
          wr_fire      = 1'b1;
          nxt_wr_state = PIO_WR_RESP;
        end
      end
      PIO_WR_RESP:
      begin
        if (ce && s_axil_bready)
        begin
          nxt_wr_state = PIO_WR_IDLE;
        end
      end
    endcase
  end

  assign wr_addr  = (wr_state_ff == PIO_WR_ADDR) ? awaddr_ff : s_axil_awaddr;
  assign wr_byte  = (wr_state_ff == PIO_WR_DATA) ? wdata_ff[7:0]
                                                 : s_axil_wdata[7:0];
  assign wr_lane0 = (wr_state_ff == PIO_WR_DATA) ? wstrb_ff[0]
                                                 : s_axil_wstrb[0];
  assign {wr_is_dir, wr_port} = pio_decode(wr_addr[`PIO_ADDR_IDX]);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_state_ff <= PIO_WR_IDLE;
    end
    else if (ce)
    begin
      wr_state_ff <= nxt_wr_state;
    end
  end

  // captured halves of a split write
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axil_awready && s_axil_awvalid)
      begin
        awaddr_ff <= s_axil_awaddr;
      end
      if (s_axil_wready && s_axil_wvalid)
      begin
        wdata_ff <= s_axil_wdata;
        wstrb_ff <= s_axil_wstrb;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      bresp_ff <= `PIO_RESP_OKAY;
    end
    else if (ce && wr_fire)
    begin
      bresp_ff <= (wr_addr[`PIO_ADDR_HI] != 2'h0) ? `PIO_RESP_DECERR
                                                  : `PIO_RESP_OKAY;
    end
  end

  assign s_axil_bvalid = ce && (wr_state_ff == PIO_WR_RESP);
  assign s_axil_bresp  = bresp_ff;

  // data latches carry no reset
  always_ff @(posedge clk_sys)
  begin
    if (ce && wr_fire && wr_lane0 && !wr_is_dir &&
        wr_addr[`PIO_ADDR_HI] == 2'h0)
    begin
      latch_ff[wr_port] <= wr_byte & mask_data[wr_port];
    end
  end

  // direction registers, cleared to inputs on reset
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dir_ff <= `PIO_DIR_RESET;
    end
    else if (ce && wr_fire && wr_lane0 && wr_is_dir &&
             wr_addr[`PIO_ADDR_HI] == 2'h0)
    begin
      dir_ff[wr_port] <= wr_byte & mask_dir[wr_port];
    end
  end

  // per-bit read view and pin drive
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1)
    begin : g_pin
      localparam int P = g / 8;
      localparam int B = g % 8;
      if (P == 1)
      begin : g_adc
        assign pin_view[P][B] = dir_ff[P][B] ? latch_ff[P][B]
          : (converter_pin_claim[B] ? 1'b0 : sif.synced[P][B]);
        assign pin_oe[P][B] = dir_ff[P][B] && !converter_pin_claim[B];
        assign pin_out[P][B] = latch_ff[P][B];
      end
      else if (P == 2 && B == `PIO_CLKOUT_PIN)
      begin : g_clk
        assign pin_view[P][B] = clk_out_en ? 1'b0
          : (dir_ff[P][B] ? latch_ff[P][B] : sif.synced[P][B]);
        assign pin_oe[P][B]  = clk_out_en || dir_ff[P][B];
        assign pin_out[P][B] = clk_out_en ? clk_sys : latch_ff[P][B];
      end
      else
      begin : g_gpio
        assign pin_view[P][B] = mask_data[P][B] && (dir_ff[P][B]
          ? latch_ff[P][B] : sif.synced[P][B]);
        assign pin_oe[P][B] = mask_data[P][B] && dir_ff[P][B];
        assign pin_out[P][B] = mask_data[P][B] && latch_ff[P][B];
      end
    end
  endgenerate

  // read channel
  assign {rd_is_dir, rd_port} = pio_decode(s_axil_araddr[`PIO_ADDR_IDX]);
  assign rd_byte        = rd_is_dir ? dir_ff[rd_port] : pin_view[rd_port];
  assign s_axil_arready = ce && !rvalid_ff;
  assign ar_fire        = s_axil_arready && s_axil_arvalid;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `PIO_RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_fire)
      begin
        rvalid_ff <= 1'b1;
        if (s_axil_araddr[`PIO_ADDR_HI] != 2'h0)
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= `PIO_RESP_DECERR;
        end
        else
        begin
          rdata_ff <= {24'h00_0000, rd_byte};
          rresp_ff <= `PIO_RESP_OKAY;
        end
      end
      else if (s_axil_rready)
      begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axil_rvalid = ce && rvalid_ff;
  assign s_axil_rdata  = rdata_ff;
  assign s_axil_rresp  = rresp_ff;
endmodule
`default_nettype wire

// ### tb/pio_top_asserts.sv
// port checks for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module pio_top_asserts (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic [7:0]         s_axil_awaddr,
  input wire logic               s_axil_awvalid,
  input wire logic               s_axil_awready,
  input wire logic [31:0]        s_axil_wdata,
  input wire logic [3:0]         s_axil_wstrb,
  input wire logic               s_axil_wvalid,
  input wire logic               s_axil_wready,
  input wire logic [7:0]         s_axil_araddr,
  input wire logic               s_axil_arvalid,
  input wire logic               s_axil_arready,
  input wire logic [31:0]        s_axil_rdata,
  input wire logic [1:0]         s_axil_rresp,
  input wire logic               s_axil_rvalid,
  input wire pio_pkg::pio_pins_t pin_in,
  input wire pio_pkg::pio_pins_t pin_oe,
  input wire logic [4:0]         converter_channel_select,
  input wire logic [7:0]         converter_channel_inputs,
  input wire logic [7:0]         converter_pin_claim
);
  import pio_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence s_wr_dir_a;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
      && s_axil_wstrb[0] && s_axil_awaddr == 8'h10;
  endsequence
  sequence s_rd_take;
    s_axil_arvalid && s_axil_arready;
  endsequence
  property p_oe_rst;
    $rose(resetn) |-> pin_oe[0] == 8'h00 && pin_oe[1] == 8'h00;
  endproperty
  a_oe_rst: assert property (p_oe_rst)
    else $error("pins driven after reset");
  property p_claim;
    converter_pin_claim == (converter_channel_select < 5'h08 ?
      8'h01 << converter_channel_select[2:0] : 8'h00);
  endproperty
  a_claim: assert property (p_claim)
    else $error("wrong converter claim");
  property p_hiz;
    (converter_pin_claim & pin_oe[1]) == 8'h00;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("claimed pin driven");
  property p_conv;
    converter_channel_inputs == pin_in[1];
  endproperty
  a_conv: assert property (p_conv)
    else $error("converter inputs differ from pins");
  property p_dir;
    s_wr_dir_a |=> pin_oe[0] == $past(s_axil_wdata[7:0]);
  endproperty
  a_dir: assert property (p_dir)
    else $error("enable not from direction write");
  property p_rd;
    s_rd_take |=> s_axil_rvalid;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read not answered");
  property p_unmap;
    s_rd_take ##0 (s_axil_araddr[7:6] != 2'h0)
      |=> s_axil_rresp == 2'h3 && s_axil_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not refused");
  property p_upper;
    s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits set");
endmodule
bind pio_top pio_top_asserts u_chk (.*);
`default_nettype wire

// ### tb/pio_pins_model.sv
// pins and outside levels beyond the port block
`timescale 1ns/1ps
`default_nettype none
module pio_pins_model (
  input  wire pio_pkg::pio_pins_t pin_out,
  input  wire pio_pkg::pio_pins_t pin_oe,
  input  wire pio_pkg::pio_pins_t ext_lvl,
  output var pio_pkg::pio_pins_t  pin_in
);
  import pio_pkg::*;
  // driven pin shows its own output, released pin the outside level
  always_comb
    for (int p = 0; p < 8; p++)
      pin_in[p] = (pin_oe[p] & pin_out[p]) | (~pin_oe[p] & ext_lvl[p]);
endmodule
`default_nettype wire

// ### tb/pio_top_tb.sv
// register-level bench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module pio_top_tb;
  import pio_pkg::*;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  s_axil_awaddr = 8'h00;
  logic [7:0]  s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0;
  logic [3:0]  s_axil_wstrb = 4'hf;
  logic        s_axil_awvalid = 1'b0;
  logic        s_axil_wvalid = 1'b0;
  logic        s_axil_bready = 1'b0;
  logic        s_axil_arvalid = 1'b0;
  logic        s_axil_rready = 1'b0;
  logic        s_axil_awready;
  logic        s_axil_wready;
  logic        s_axil_bvalid;
  logic        s_axil_arready;
  logic        s_axil_rvalid;
  logic [1:0]  s_axil_bresp;
  logic [1:0]  s_axil_rresp;
  logic [31:0] s_axil_rdata;
  logic [4:0]  converter_channel_select = 5'h08;
  logic [7:0]  converter_channel_inputs;
  logic [7:0]  converter_pin_claim;
  pio_pins_t   pin_in;
  pio_pins_t   pin_out;
  pio_pins_t   pin_oe;
  pio_pins_t   ext_lvl;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          i;
  logic [2:0]  p;
  logic [7:0]  q;
  logic [7:0]  e;
  logic [1:0]  rsp;
  localparam logic [7:0] msk [8] = '{8'hff, 8'hff, 8'h3f, 8'hff,
                                     8'hff, 8'h7f, 8'h07, 8'h03};
  always #2.5 clk_sys = ~clk_sys;
  pio_top uut (.*);
  pio_pins_model u_pins (
    .pin_out (pin_out),
    .pin_oe  (pin_oe),
    .ext_lvl (ext_lvl),
    .pin_in  (pin_in)
  );
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] ev, input logic [7:0] gv);
    n_tests++;
    if (gv !== ev)
    begin
      error_cnt++;
      $display("mismatch at %0t exp %h got %h", $time, ev, gv);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [3:0] hs;
    int n;
    n = 0;
    if (w)
    begin
      s_axil_awaddr <= a;
      s_axil_wdata <= {24'h0, d};
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid <= 1'b1;
      s_axil_bready <= 1'b1;
    end
    else
    begin
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready <= 1'b1;
    end
    do
    begin
      @(negedge clk_sys);
      hs = {s_axil_awvalid & s_axil_awready, s_axil_wvalid & s_axil_wready,
            s_axil_arvalid & s_axil_arready,
            (s_axil_bready & s_axil_bvalid) | (s_axil_rready & s_axil_rvalid)};
      q = s_axil_rdata[7:0];
      rsp = w ? s_axil_bresp : s_axil_rresp;
      @(posedge clk_sys);
      if (hs[3])
        s_axil_awvalid <= 1'b0;
      if (hs[2])
        s_axil_wvalid <= 1'b0;
      if (hs[1])
        s_axil_arvalid <= 1'b0;
      n++;
    end while (!hs[0] && n < 40);
    s_axil_bready <= 1'b0;
    s_axil_rready <= 1'b0;
    // let an edge pass so the next call never re-raises a ready in this step
    @(posedge clk_sys);
    if (!hs[0])
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ev);
    acc(1'b0, a, 8'h00);
    chk(ev, q);
  endtask
  initial
  begin
    ext_lvl = '0;
    ext_lvl[0] = 8'h5a;
    ext_lvl[1] = 8'h3c;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    chk(8'h00, pin_oe[0]);
    chk(8'h00, pin_oe[1]);
    acc(1'b1, 8'h00, 8'ha5);
    chk(8'h00, {6'h0, rsp});
    acc(1'b1, 8'h10, 8'hf0);
    rd(8'h00, 8'haa);
    chk(8'ha0, pin_out[0] & 8'hf0);
    acc(1'b1, 8'h00, 8'h0f);
    rd(8'h00, 8'h0a);
    acc(1'b1, 8'h04, 8'hc3);
    acc(1'b1, 8'h14, 8'h0f);
    rd(8'h04, 8'h33);
    for (i = 0; i < 8; i++)
    begin
      converter_channel_select <= 5'(i);
      @(posedge clk_sys);
      e = 8'h01 << i;
      rd(8'h04, (8'h33 & ~e) | (8'h03 & e));
      chk(8'h0f & ~e, pin_oe[1]);
    end
    converter_channel_select <= 5'h08;
    for (i = 0; i < 16; i++)
      acc(1'b1, {2'h0, 4'(i), 2'h0}, 8'hff);
    for (i = 0; i < 16; i++)
    begin
      p = {i[3], i[1:0]};
      e = msk[p];
      if (i == 6)
        e = 8'hbf;
      if (i == 2)
        e = 8'h3b;
      rd({2'h0, 4'(i), 2'h0}, e);
      chk(msk[p], pin_oe[p]);
    end
    @(negedge clk_sys);
    #1;
    chk(8'h00, {7'h0, pin_out[2][2]});
    @(posedge clk_sys);
    #1;
    chk(8'h01, {7'h0, pin_out[2][2]});
    @(posedge clk_sys);
    acc(1'b1, 8'h40, 8'h55);
    chk(8'h03, {6'h0, rsp});
    rd(8'h40, 8'h00);
    chk(8'h03, {6'h0, rsp});
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    chk(8'h00, pin_oe[0]);
    rd(8'h14, 8'h00);
    acc(1'b1, 8'h10, 8'hff);
    rd(8'h00, 8'hff);
    tally_and_finish();
  end
endmodule
`default_nettype wire
